// *** hdl/meci_top.sv ***
/*
  meter error correction and volume difference alarm, with an
  AXI4-Lite register slave.
  assumes impulse strobes and flow_rate synchronous to clk, flow in
  whole m3/h, and counters counting one unit per impulse.
*/
`timescale 1ns/10ps
module meci_top import meci_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int INTV = INTV_SECS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic pulse_one,
  input wire logic pulse_two,
  input wire logic [15:0] flow_rate,
  output logic [15:0] correction_factor,
  output logic alarm_volume_difference,
  output logic status_log_evt,
  output logic interval_log_evt,
  output logic irq
);
  localparam logic [3:0] IX_N = 4'(N_PTS);
  typedef struct packed {
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic b_v;
    logic [1:0] b_r;
    logic r_v;
    logic [1:0] r_r;
    logic [31:0] r_d;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [15:0] trig;
    logic [N_PTS-1:0][15:0] qp;
    logic [N_PTS-1:0][15:0] cp;
    logic [15:0] cf;
    logic [31:0] sec;
    logic [7:0] pc;
    logic rate_hi;
    meci_st_t st;
    logic start;
    logic [31:0] num;
    logic [15:0] den;
    logic [15:0] base;
    logic neg;
    logic slog;
    logic ilog;
  } meci_top_t;
  meci_top_t q, n;

  meci_div_if #(.W(32)) dv ();
  logic [31:0] cnt_one;
  logic [31:0] cnt_two;
  logic vd_evt;
  logic sec_tick;
  logic wr_one;
  logic wr_two;
  logic [31:0] wm;
  logic bad;
  logic [32:0] rw;
  logic [N_PTS-2:0] seg;
  logic [3:0] lst;
  logic [3:0] si;
  logic [15:0] cmax;
  logic apply;
  logic atmax;
  logic [15:0] dc;
  logic [15:0] dq;

  if (SEC_CYCLES < 2 || N_PTS < 2 || N_PTS > 16) begin : g_bad
    $error("meci_top: unsupported parameter value");
  end

  function automatic logic [32:0] rd_word(input logic [7:0] a);
    logic [3:0] ix;
    ix = a[5:2];
    rd_word = {1'b1, 32'h0};
    case ({a[7:2], 2'h0})
      A_STAT: rd_word[31:0] = {30'h0, q.stat};
      A_MASK: rd_word[31:0] = {30'h0, q.mask};
      A_TRIG: rd_word[31:0] = {16'h0, q.trig};
      A_CNT1: rd_word[31:0] = cnt_one;
      A_CNT2: rd_word[31:0] = cnt_two;
      A_CF: rd_word[31:0] = {16'h0, q.cf};
      default: begin
        if (a[7:6] == A_FLOW && ix < IX_N) begin
          rd_word[31:0] = {16'h0, q.qp[ix]};
        end else if (a[7:6] == A_FACT && ix < IX_N) begin
          rd_word[31:0] = {16'h0, q.cp[ix]};
        end else begin
          rd_word = 33'h0;
        end
      end
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] v, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? v[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // a zero-flow slot is never the upper end of a segment
  for (genvar g = 0; g < N_PTS - 1; g++) begin : g_seg
    assign seg[g] = q.qp[g+1] != 16'h0 && flow_rate >= q.qp[g] &&
      flow_rate < q.qp[g+1];
  end

  always_comb begin
    lst = 4'h0;
    si = 4'h0;
    for (int i = 1; i < N_PTS; i++) begin
      if (q.qp[i] != 16'h0) lst = 4'(i);
    end
    for (int i = N_PTS - 2; i >= 0; i--) begin
      if (seg[i]) si = 4'(i);
    end
  end

  assign cmax = q.cp[lst];
  assign apply = q.rate_hi || flow_rate >= q.qp[0];
  assign atmax = lst != 4'h0 && flow_rate >= q.qp[lst];
  assign sec_tick = q.sec == 32'(SEC_CYCLES - 1);
  always_comb rw = rd_word(q.aw_a);
  assign wm = merge(rw[31:0], q.w_d, q.w_s);
  assign dc = q.cp[si+4'h1] >= q.cp[si] ?
    q.cp[si+4'h1] - q.cp[si] : q.cp[si] - q.cp[si+4'h1];
  assign dq = flow_rate - q.qp[si];

  always_comb begin
    n = q;
    n.start = 1'b0;
    n.slog = 1'b0;
    n.ilog = 1'b0;
    wr_one = 1'b0;
    wr_two = 1'b0;
    bad = 1'b0;
    if (s_axi_awvalid && !q.aw_v) begin
      n.aw_v = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_v) begin
      n.w_v = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (q.b_v && s_axi_bready) n.b_v = 1'b0;
    if (q.aw_v && q.w_v && !q.b_v) begin
      n.aw_v = 1'b0;
      n.w_v = 1'b0;
      n.b_v = 1'b1;
      case ({q.aw_a[7:2], 2'h0})
        A_STAT: n.stat = q.stat & ~wm[1:0];
        A_MASK: n.mask = wm[1:0];
        A_TRIG: n.trig = wm[15:0];
        A_CNT1: wr_one = 1'b1;
        A_CNT2: wr_two = 1'b1;
        default: begin
          if (!rw[32] || q.aw_a[7:6] == 2'h0) begin
            bad = 1'b1;
          end else if (q.aw_a[7:6] == A_FLOW) begin
            if (wm[31:16] == 16'h0 && wm[15:0] <= FLOW_MAX)
              n.qp[q.aw_a[5:2]] = wm[15:0];
            else
              bad = 1'b1;
          end else begin
            if (wm[31:16] == 16'h0 && wm[15:0] >= CF_MIN &&
                wm[15:0] <= CF_MAX)
              n.cp[q.aw_a[5:2]] = wm[15:0];
            else
              bad = 1'b1;
          end
        end
      endcase
      n.b_r = bad ? RESP_ERR : RESP_OK;
    end
    if (q.r_v && s_axi_rready) n.r_v = 1'b0;
    if (s_axi_arvalid && !q.r_v) begin
      n.r_v = 1'b1;
      {n.r_r[1], n.r_d} = rd_word(s_axi_araddr);
      n.r_r = n.r_r[1] ? RESP_OK : RESP_ERR;
    end
    // impulse rate over the last whole second
    n.sec = sec_tick ? 32'h0 : q.sec + 32'h1;
    if (sec_tick) begin
      n.rate_hi = q.pc > RATE_MIN;
      n.pc = {7'h0, pulse_one};
    end else if (pulse_one && q.pc != 8'hFF) begin
      n.pc = q.pc + 8'h1;
    end
    case (q.st)
      S_IDLE: begin
        if (!apply) begin
          n.cf = CF_ONE;
        end else if (atmax) begin
          n.cf = cmax;
        end else if (|seg) begin
          n.start = 1'b1;
          n.st = S_WAIT;
          n.base = q.cp[si];
          n.neg = q.cp[si+4'h1] < q.cp[si];
          n.num = {16'h0, dc} * {16'h0, dq};
          n.den = q.qp[si+4'h1] - q.qp[si];
        end else begin
          // below the first checkpoint but pulsing fast
          n.cf = q.cp[0];
        end
      end
      S_WAIT: begin
        if (dv.done) begin
          n.st = S_IDLE;
          n.cf = q.neg ? q.base - dv.quot[15:0] :
            q.base + dv.quot[15:0];
        end
      end
      default: n.st = S_IDLE;
    endcase
    // hardware set wins over a clear in the same cycle
    if (bad) n.stat[ST_RANGE] = 1'b1;
    if (vd_evt) begin
      n.stat[ST_VDIFF] = 1'b1;
      n.slog = 1'b1;
      n.ilog = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.cp <= {N_PTS{CF_ONE}};
      q.cf <= CF_ONE;
      q.st <= S_IDLE;
    end else begin
      q <= n;
    end
  end

  assign dv.start = q.start;
  assign dv.num = q.num;
  assign dv.den = q.den;

  meci_div #(.W(32)) u_div (
    .clk(clk),
    .rst(rst),
    .d(dv.srv)
  );

  meci_vdiff #(.INTV(INTV)) u_vdiff (
    .clk(clk),
    .rst(rst),
    .pulse_one(pulse_one),
    .pulse_two(pulse_two),
    .sec_tick(sec_tick),
    .trig(q.trig),
    .wr_one(wr_one),
    .wr_two(wr_two),
    .wr_val(wm),
    .cnt_one(cnt_one),
    .cnt_two(cnt_two),
    .alarm_evt(vd_evt)
  );

  assign s_axi_awready = !q.aw_v;
  assign s_axi_wready = !q.w_v;
  assign s_axi_bvalid = q.b_v;
  assign s_axi_bresp = q.b_r;
  assign s_axi_arready = !q.r_v;
  assign s_axi_rvalid = q.r_v;
  assign s_axi_rdata = q.r_d;
  assign s_axi_rresp = q.r_r;
  assign correction_factor = q.cf;
  assign alarm_volume_difference = q.stat[ST_VDIFF];
  assign status_log_evt = q.slog;
  assign interval_log_evt = q.ilog;
  assign irq = |(q.stat & q.mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_go;
    q.aw_v && q.w_v && !q.b_v && q.w_s == 4'hF;
  endsequence
  sequence s_flow_bad;
    s_wr_go ##0 q.aw_a[7:6] == A_FLOW && q.w_d[15:0] > FLOW_MAX;
  endsequence
  sequence s_fact_bad;
    s_wr_go ##0 q.aw_a[7:6] == A_FACT &&
      (q.w_d[15:0] < CF_MIN || q.w_d[15:0] > CF_MAX);
  endsequence
  a_flow_range: assert property (s_flow_bad |=> s_axi_bvalid &&
      s_axi_bresp == RESP_ERR && $stable(q.qp))
    else $error("out of range flow stored");
  a_fact_range: assert property (s_fact_bad |=>
      $stable(q.cp) && q.stat[ST_RANGE])
    else $error("out of range factor stored");
  a_cf_unity: assert property (q.st == S_IDLE && !apply
      |=> correction_factor == CF_ONE)
    else $error("factor not one without correction");
  a_cf_hold_max: assert property (q.st == S_IDLE && apply && atmax
      |=> correction_factor == $past(cmax))
    else $error("factor not held above maximum flow");
  a_seg_start: assert property (q.st == S_IDLE && apply && !atmax &&
      |seg |=> dv.start ##1 q.st == S_WAIT)
    else $error("interpolation not started");
  a_log_pair: assert property (vd_evt |=> status_log_evt &&
      interval_log_evt && alarm_volume_difference)
    else $error("alarm not logged in both logs");
endmodule

// *** shared/meci_pkg.sv ***
/*
  constants, register map and types of the meter error correction
  and volume difference alarm block.
  assumes one 20 MHz clock and an AXI4-Lite master.
*/
package meci_pkg;
  localparam int N_PTS = 10;
  localparam logic [15:0] FLOW_MAX = 16'h2710;
  // factors are scaled by 10000
  localparam logic [15:0] CF_ONE = 16'h2710;
  localparam logic [15:0] CF_MIN = 16'h2328;
  localparam logic [15:0] CF_MAX = 16'h2AF8;
  localparam logic [7:0] RATE_MIN = 8'h0A;
  localparam int CLK_HZ = 20_000_000;
  localparam int SEC_S = 1;
  localparam int SEC_CYC = CLK_HZ * SEC_S;
  localparam int INTV_MIN = 5;
  localparam int INTV_SECS = INTV_MIN * 60 / SEC_S;
  localparam logic [7:0] A_STAT = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_TRIG = 8'h08;
  localparam logic [7:0] A_CNT1 = 8'h0C;
  localparam logic [7:0] A_CNT2 = 8'h10;
  localparam logic [7:0] A_CF = 8'h14;
  localparam logic [1:0] A_FLOW = 2'h1;
  localparam logic [1:0] A_FACT = 2'h2;
  localparam int ST_VDIFF = 0;
  localparam int ST_RANGE = 1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {S_IDLE = 2'h1, S_WAIT = 2'h2} meci_st_t;
endpackage

// *** shared/meci_div_if.sv ***
/*
  request and answer of the unsigned divider.
  assumes one request at a time, started only while idle.
*/
`timescale 1ns/10ps
interface meci_div_if #(parameter int W = 32);
  logic start;
  logic [W-1:0] num;
  logic [15:0] den;
  logic done;
  logic [W-1:0] quot;
  modport req (output start, output num, output den,
    input done, input quot);
  modport srv (input start, input num, input den,
    output done, output quot);
endinterface

// *** hdl/meci_div.sv ***
/*
  restoring divider, one quotient bit per clock.
  assumes den is nonzero and start comes only while idle.
*/
`timescale 1ns/10ps
module meci_div import meci_pkg::*; #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  meci_div_if.srv d
);
  localparam int DIV_LAT = W + 1;
  typedef struct packed {
    logic [W-1:0] q;
    logic [16:0] r;
    logic [15:0] den;
    logic [5:0] n;
    logic busy;
    logic done;
    logic [W-1:0] quot;
  } meci_dv_t;
  meci_dv_t q, n;
  logic [16:0] r2;

  if (W < 2 || W > 32) begin : g_bad
    $error("meci_div: W must be 2..32");
  end

  always_comb begin
    n = q;
    n.done = 1'b0;
    r2 = {q.r[15:0], q.q[W-1]};
    if (d.start) begin
      n.busy = 1'b1;
      n.q = d.num;
      n.r = 17'h0;
      n.den = d.den;
      n.n = 6'(W);
    end else if (q.busy) begin
      if (r2 >= {1'b0, q.den}) begin
        n.r = r2 - {1'b0, q.den};
        n.q = {q.q[W-2:0], 1'b1};
      end else begin
        n.r = r2;
        n.q = {q.q[W-2:0], 1'b0};
      end
      n.n = q.n - 6'h1;
      if (q.n == 6'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.quot = n.q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign d.done = q.done;
  assign d.quot = q.quot;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_div_latency: assert property (d.start |-> ##DIV_LAT d.done)
    else $error("divider answer not on time");
endmodule

// *** hdl/meci_vdiff.sv ***
/*
  raw counters of both impulse inputs, hidden shadow of input two
  and the interval difference check.
  assumes pulses and sec_tick are one-cycle strobes of clk.
*/
`timescale 1ns/10ps
module meci_vdiff import meci_pkg::*; #(
  parameter int INTV = INTV_SECS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pulse_one,
  input wire logic pulse_two,
  input wire logic sec_tick,
  input wire logic [15:0] trig,
  input wire logic wr_one,
  input wire logic wr_two,
  input wire logic [31:0] wr_val,
  output logic [31:0] cnt_one,
  output logic [31:0] cnt_two,
  output logic alarm_evt
);
  typedef struct packed {
    logic [31:0] c1;
    logic [31:0] c2;
    logic [31:0] sh;
    logic [15:0] isec;
    logic evt;
  } meci_vd_t;
  meci_vd_t q, n;
  logic iv_end;
  logic [31:0] diff;

  if (INTV < 1 || INTV > 65535) begin : g_bad
    $error("meci_vdiff: INTV must be 1..65535");
  end

  assign iv_end = sec_tick && q.isec == 16'(INTV - 1);
  // raw counts only, never converted volume
  assign diff = q.sh >= q.c1 ? q.sh - q.c1 : q.c1 - q.sh;

  always_comb begin
    n = q;
    n.evt = 1'b0;
    if (wr_one) n.c1 = wr_val;
    else if (pulse_one) n.c1 = q.c1 + 32'h1;
    if (wr_two) n.c2 = wr_val;
    else if (pulse_two) n.c2 = q.c2 + 32'h1;
    // a software write to counter two leaves the shadow behind
    if (pulse_two) n.sh = q.sh + 32'h1;
    if (iv_end) n.isec = 16'h0;
    else if (sec_tick) n.isec = q.isec + 16'h1;
    if (iv_end && trig != 16'h0 && diff > {16'h0, trig}) begin
      n.evt = 1'b1;
      n.sh = n.c2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cnt_one = q.c1;
  assign cnt_two = q.c2;
  assign alarm_evt = q.evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_diff_fire: assert property (iv_end && trig != 16'h0 &&
      diff > {16'h0, trig} |=> alarm_evt)
    else $error("difference above trigger not flagged");
  a_diff_off: assert property (trig == 16'h0 |=> !alarm_evt)
    else $error("alarm while function switched off");
  a_shadow_load: assert property (alarm_evt |-> q.sh == q.c2)
    else $error("shadow not reloaded from counter two");
  a_shadow_track: assert property (pulse_two && !iv_end
      |=> q.sh == $past(q.sh) + 32'h1)
    else $error("shadow missed an input two pulse");
endmodule

// *** test/meci_meter_model.sv ***
/*
  impulse outputs of the two gas meters on the far side.
  assumes the block's clk; a period of zero stops that input.
*/
`timescale 1ns/10ps
module meci_meter_model (
  input wire logic clk,
  input wire logic [7:0] per_one,
  input wire logic [7:0] per_two,
  output logic pulse_one,
  output logic pulse_two,
  output logic [31:0] n_one,
  output logic [31:0] n_two
);
  logic [7:0] c_one = 8'h00;
  logic [7:0] c_two = 8'h00;
  logic p_one = 1'b0;
  logic p_two = 1'b0;
  logic [31:0] k_one = 32'h0;
  logic [31:0] k_two = 32'h0;
  assign pulse_one = p_one;
  assign pulse_two = p_two;
  assign n_one = k_one;
  assign n_two = k_two;
  // one-cycle strobes; the period sets a fast or a slow meter
  always @(posedge clk) begin
    p_one <= per_one != 8'h00 && c_one == 8'h00;
    p_two <= per_two != 8'h00 && c_two == 8'h00;
    if (per_one != 8'h00 && c_one == 8'h00) k_one <= k_one + 32'h1;
    if (per_two != 8'h00 && c_two == 8'h00) k_two <= k_two + 32'h1;
    c_one <= (c_one + 8'h01 >= per_one) ? 8'h00 : c_one + 8'h01;
    c_two <= (c_two + 8'h01 >= per_two) ? 8'h00 : c_two + 8'h01;
  end
endmodule

// *** test/meci_top_bench.sv ***
/*
  self-checking bench of the correction and difference alarm block.
  assumes a short second (100 cycles) and a two-second interval.
*/
`timescale 1ns/10ps
module meci_top_bench import meci_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00, p1 = 8'h00, p2 = 8'h00;
  logic [31:0] wd = 32'h0, seed = 32'h00012ADE, v;
  logic [3:0] ws = 4'hF;
  logic [15:0] flow = 16'h0000;
  logic [1:0] r;
  logic awr, wrdy, bv, arr, rv, irq, alarm, slog, ilog, po, pt, fast;
  logic [1:0] br, rr, rsp;
  logic [31:0] rd, n1, n2;
  logic [15:0] cf;
  int n_mismatch = 0, cmp_count = 0, n_log = 0, i;
  logic [15:0] fl[3] = '{16'h0064, 16'h00C8, 16'h012C};
  // factors 100/(error+100) x10000 for errors of +2.04, -1.96, -3.85 %
  logic [15:0] cfv[3] = '{16'h2648, 16'h27D8, 16'h28A0};
  logic [7:0] ta[10] = '{8'h40, 8'h40, 8'h80, 8'h80, 8'h68, 8'hFC,
    A_CF, 8'h80, 8'h80, 8'h40};
  logic [31:0] td[10] = '{32'h2711, 32'h10000, 32'h2327, 32'h2AF9, 32'h0,
    32'h0, 32'h0, {16'h0, CF_MIN}, {16'h0, CF_MAX}, {16'h0, FLOW_MAX}};

  meci_top #(.SEC_CYCLES(100), .INTV(2)) meci_top_inst (
    .clk(clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .pulse_one(po), .pulse_two(pt), .flow_rate(flow),
    .correction_factor(cf), .alarm_volume_difference(alarm),
    .status_log_evt(slog), .interval_log_evt(ilog), .irq(irq));
  meci_meter_model meci_meter_model_inst (.clk(clk), .per_one(p1),
    .per_two(p2), .pulse_one(po), .pulse_two(pt), .n_one(n1), .n_two(n2));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    $display("mismatch wait ran out");
    wrap_up();
  endtask

  // status and interval log must fire together
  always @(posedge clk) begin
    if (!rst && (slog || ilog)) begin
      n_log++;
      chk("log_pair", ilog, slog);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] resp);
    int n;
    bit ka, kw;
    n = 0;
    ka = 0;
    kw = 0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    while (!(ka && kw)) begin
      @(posedge clk);
      if (!ka && awr) begin
        ka = 1;
        awv <= 1'b0;
      end
      if (!kw && wrdy) begin
        kw = 1;
        wv <= 1'b0;
      end
      n++;
      if (n > 50) hang();
    end
    while (bv !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 50) hang();
    end
    resp = br;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
      if (n > 50) hang();
    end while (rv !== 1'b1);
    d = rd;
    rsp = rr;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] exp_cf(input int f, input bit fq);
    int k;
    if (f < fl[0]) return fq ? cfv[0] : CF_ONE;
    if (f >= fl[2]) return cfv[2];
    k = f < fl[1] ? 0 : 1;
    return 16'(cfv[k] + (f - fl[k]) * (cfv[k+1] - cfv[k])
      / (fl[k+1] - fl[k]));
  endfunction

  // a divide in flight ends first, so allow two divides of 35 cycles
  task automatic setf(input logic [15:0] f);
    @(posedge clk);
    flow <= f;
    repeat (80) @(posedge clk);
    chk("factor", cf, exp_cf(f, fast));
  endtask

  task automatic until_alarm(input int lim);
    int n;
    n = 0;
    while (alarm !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > lim) hang();
    end
  endtask

  initial begin
    fast = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdr(A_STAT, v);
    chk("status", v, 32'h0);
    rdr(A_TRIG, v);
    chk("trigger", v, 32'h0);
    ws <= 4'h2;
    wr(A_TRIG, 32'h00001234, r);
    ws <= 4'hF;
    rdr(A_TRIG, v);
    chk("trig_strobe", v, 32'h00001200);
    wr(A_TRIG, 32'h0, r);
    rdr(A_CF, v);
    chk("factor_reg", v, {16'h0, CF_ONE});
    for (i = 0; i < 10; i++) begin
      wr(ta[i], td[i], r);
      chk("resp", r, i > 6 ? RESP_OK : RESP_ERR);
    end
    rdr(A_STAT, v);
    chk("range_flag", v, 32'h2);
    wr(A_STAT, 32'h2, r);
    rdr(A_STAT, v);
    chk("range_clr", v, 32'h0);
    rdr(8'h80, v);
    chk("fact0", v, {16'h0, CF_MAX});
    chk("fact0_resp", rsp, RESP_OK);
    rdr(8'h68, v);
    chk("slot10", v, 32'h0);
    chk("slot10_resp", rsp, RESP_ERR);
    // increasing checkpoints, unused slots flow zero
    for (i = 0; i < 10; i++) begin
      wr(8'h40 + 8'(4 * i), i < 3 ? {16'h0, fl[i]} : 32'h0, r);
      wr(8'h80 + 8'(4 * i), {16'h0, i < 3 ? cfv[i] : CF_ONE}, r);
    end
    setf(16'h0032);
    setf(16'h00FA);
    p1 <= 8'h0A; // exactly ten per second: not above the threshold
    repeat (250) @(posedge clk);
    setf(16'h0032);
    p1 <= 8'h09;
    fast = 1'b1;
    repeat (250) @(posedge clk);
    setf(16'h0032);
    setf(FLOW_MAX);
    setf(16'h012C);
    for (i = 0; i < 8; i++) setf(16'(xs() % 400));
    p1 <= 8'h00;
    repeat (20) @(posedge clk);
    rdr(A_CNT1, v);
    chk("counter1", v, n1);
    chk("alarm_off", alarm, 1'b0);
    wr(A_CNT1, 32'h0, r);
    wr(A_CNT2, 32'h1000, r);
    wr(A_MASK, 32'h1, r);
    wr(A_TRIG, 32'h64, r);
    // meters in step: shadow matches counter one, counter two does not
    p1 <= 8'h09;
    p2 <= 8'h09;
    repeat (600) @(posedge clk);
    chk("alarm_below", alarm, 1'b0);
    p2 <= 8'h00;
    wr(A_TRIG, 32'h1 + xs() % 20, r);
    until_alarm(800);
    p1 <= 8'h00;
    chk("irq", irq, 1'b1);
    rdr(A_STAT, v);
    chk("logged", n_log != 0, 1'b1);
    chk("status_alarm", v[0], 1'b1);
    wr(A_MASK, 32'h0, r);
    chk("irq_masked", irq, 1'b0);
    wr(A_MASK, 32'h1, r);
    rdr(A_CNT2, v);
    chk("counter2", v, 32'h1000 + n2);
    // shadow now equals counter2, so equal counters stay quiet
    wr(A_CNT1, v, r);
    wr(A_STAT, 32'h1, r);
    chk("irq_clr", irq, 1'b0);
    repeat (600) @(posedge clk);
    chk("alarm_resync", alarm, 1'b0);
    wrap_up();
  end
endmodule
